// ===== core/eif_pkg.sv
// Shared constants and types for the encoder input front end
package eif_pkg;

    // ==========================================================
    // Bus geometry
    localparam int EIF_AW = 8;
    localparam int EIF_DW = 32;

    // ==========================================================
    // Register offsets (byte addresses)
    localparam logic [7:0] EIF_CTRL_OFS = 8'h00;
    localparam logic [7:0] EIF_STAT_OFS = 8'h04;

    // ==========================================================
    // Control register field positions
    localparam int EIF_CTRL_W = 10;
    localparam int EIF_F_SRC24 = 0;
    localparam int EIF_F_PULSE = 1;
    localparam int EIF_F_INV = 2;
    localparam int EIF_F_EVAL = 3;
    localparam int EIF_F_ZEN = 5;
    localparam int EIF_F_MON = 6;
    localparam int EIF_F_FSHORT = 9;

    // Differential, no inversion, all pairs monitored, single, zero load off, long filter
    localparam logic [EIF_CTRL_W-1:0] EIF_CTRL_RST = 10'h1c0;

    // ==========================================================
    // Edge evaluation modes
    typedef enum logic [1:0] {
        EIF_EV_SINGLE = 2'b00,
        EIF_EV_DOUBLE = 2'b01,
        EIF_EV_FOUR = 2'b10,
        EIF_EV_RSVD = 2'b11
    } eif_eval_type;

    // ==========================================================
    // Timing
    localparam int EIF_CLK_PERIOD_PS = 10000;
    localparam int EIF_FILT_SHORT_PS = 1500000;
    localparam int EIF_FILT_LONG_PS = 16000000;
    localparam int EIF_FAULT_PS = 1000000;
    localparam int EIF_FILT_SHORT_CYC = (EIF_FILT_SHORT_PS + EIF_CLK_PERIOD_PS - 1) / EIF_CLK_PERIOD_PS;
    localparam int EIF_FILT_LONG_CYC = (EIF_FILT_LONG_PS + EIF_CLK_PERIOD_PS - 1) / EIF_CLK_PERIOD_PS;
    localparam int EIF_FAULT_CYC = (EIF_FAULT_PS + EIF_CLK_PERIOD_PS - 1) / EIF_CLK_PERIOD_PS;
    localparam int EIF_CNT_W = 11;

endpackage

// ===== core/eif_filter.sv
// Stable-level filter for the 24 V counter inputs
`timescale 1ns/1ns
module eif_filter #(
    parameter int N = 3,
    parameter int CW = eif_pkg::EIF_CNT_W
) (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    input wire logic short_i,
    input wire logic [N-1:0] in_i,
    output logic [N-1:0] out_o
);
    import eif_pkg::*;

    // ==========================================================
    // Limit selection
    localparam logic [CW-1:0] LIM_SHORT = CW'(EIF_FILT_SHORT_CYC - 1);
    localparam logic [CW-1:0] LIM_LONG = CW'(EIF_FILT_LONG_CYC - 1);

    logic [CW-1:0] cnt_q [N];
    logic [N-1:0] out_q;
    wire logic [CW-1:0] lim = short_i ? LIM_SHORT : LIM_LONG;

    assign out_o = out_q;

    // ==========================================================
    // Per-input stability counters
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            out_q <= '0;
            for (int i = 0; i < N; i++) begin
                cnt_q[i] <= '0;
            end
        end else if (ce_i) begin
            for (int i = 0; i < N; i++) begin
                if (in_i[i] == out_q[i]) begin
                    cnt_q[i] <= '0;
                end else if (cnt_q[i] >= lim) begin
                    out_q[i] <= in_i[i];
                    cnt_q[i] <= '0;
                end else begin
                    cnt_q[i] <= cnt_q[i] + 1'b1;
                end
            end
        end
    end

    // ==========================================================
    // Checks
    property p_filt_accept;
        @(posedge core_clk_i) disable iff (!rstn_i)
        ce_i && (in_i[0] != out_q[0]) && (cnt_q[0] >= lim) |=> out_q[0] == $past(in_i[0]);
    endproperty
    a_filt_accept: assert property (p_filt_accept) else $error("filter did not accept stable level");

    property p_filt_hold;
        @(posedge core_clk_i) disable iff (!rstn_i)
        (!ce_i || (in_i[0] == out_q[0]) || (cnt_q[0] < lim)) |=> out_q[0] == $past(out_q[0]);
    endproperty
    a_filt_hold: assert property (p_filt_hold) else $error("filter output changed too early");

endmodule

// ===== core/eif_pair_mon.sv
// Wire-break and short-circuit monitor for one differential pair
`timescale 1ns/1ns
module eif_pair_mon #(
    parameter int CW = eif_pkg::EIF_CNT_W
) (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    input wire logic en_i,
    input wire logic p_i,
    input wire logic n_i,
    output logic fault_o
);
    import eif_pkg::*;

    localparam logic [CW-1:0] LIM = CW'(EIF_FAULT_CYC - 1);

    logic [CW-1:0] cnt_q;
    logic fault_q;
    // Equal lines mean open, missing or shorted pair
    wire logic bad = (p_i == n_i);

    assign fault_o = fault_q;

    // ==========================================================
    // Persistence counter
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_q <= '0;
            fault_q <= 1'b0;
        end else if (ce_i) begin
            if (!en_i || !bad) begin
                cnt_q <= '0;
                fault_q <= 1'b0;
            end else if (cnt_q >= LIM) begin
                fault_q <= 1'b1;
            end else begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end

    // ==========================================================
    // Checks
    property p_mon_detect;
        @(posedge core_clk_i) disable iff (!rstn_i)
        ce_i && en_i && bad && (cnt_q >= LIM) |=> fault_q;
    endproperty
    a_mon_detect: assert property (p_mon_detect) else $error("pair fault not flagged");

    property p_mon_off;
        @(posedge core_clk_i) disable iff (!rstn_i)
        ce_i && !en_i |=> !fault_q;
    endproperty
    a_mon_off: assert property (p_mon_off) else $error("disabled pair raised fault");

endmodule

// ===== core/eif_front_end.sv
// Encoder input front end: source select, direction decode, filter, pair monitor
`timescale 1ns/1ns
module eif_front_end (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    input wire logic [eif_pkg::EIF_AW-1:0] addr_i,
    input wire logic [eif_pkg::EIF_DW-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [eif_pkg::EIF_DW-1:0] rdata_o,
    input wire logic a_p_i,
    input wire logic a_n_i,
    input wire logic b_p_i,
    input wire logic b_n_i,
    input wire logic z_p_i,
    input wire logic z_n_i,
    input wire logic a24_i,
    input wire logic b24_i,
    input wire logic z24_i,
    output logic fwd_pulse_o,
    output logic bwd_pulse_o,
    output logic load_req_o,
    output logic [2:0] fault_o
);
    import eif_pkg::*;

    // ==========================================================
    // Synchroniser
    wire logic [8:0] raw = {z24_i, b24_i, a24_i, z_n_i, z_p_i, b_n_i, b_p_i, a_n_i, a_p_i};
    logic [8:0] sync1_q;
    logic [8:0] sync2_q;

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else if (ce_i) begin
            sync1_q <= raw;
            sync2_q <= sync1_q;
        end
    end

    // ==========================================================
    // Control register
    logic [EIF_CTRL_W-1:0] ctrl_q;
    wire logic src24 = ctrl_q[EIF_F_SRC24];
    wire logic pulse_mode = ctrl_q[EIF_F_PULSE];
    wire logic inv = ctrl_q[EIF_F_INV];
    wire eif_eval_type eval = eif_eval_type'(ctrl_q[EIF_F_EVAL +: 2]);
    wire logic zero_en = ctrl_q[EIF_F_ZEN];
    wire logic [2:0] mon_en = ctrl_q[EIF_F_MON +: 3];
    wire logic filt_short = ctrl_q[EIF_F_FSHORT];

    wire logic sel_ctrl = (addr_i == EIF_CTRL_OFS);
    wire logic sel_stat = (addr_i == EIF_STAT_OFS);

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctrl_q <= EIF_CTRL_RST;
        end else if (ce_i && wr_i && sel_ctrl) begin
            ctrl_q <= wdata_i[EIF_CTRL_W-1:0];
        end
    end

    // ==========================================================
    // 24 V input filter
    wire logic [2:0] f24;

    eif_filter #(
        .N(3),
        .CW(EIF_CNT_W)
    ) u_filter (
        .core_clk_i(core_clk_i),
        .rstn_i(rstn_i),
        .ce_i(ce_i),
        .short_i(filt_short),
        .in_i(sync2_q[8:6]),
        .out_o(f24)
    );

    // ==========================================================
    // Pair monitors
    wire logic [2:0] mon_flag;
    wire logic [2:0] mon_eff = src24 ? 3'h0 : mon_en;

    for (genvar g = 0; g < 3; g++) begin : g_mon
        eif_pair_mon #(
            .CW(EIF_CNT_W)
        ) u_mon (
            .core_clk_i(core_clk_i),
            .rstn_i(rstn_i),
            .ce_i(ce_i),
            .en_i(mon_eff[g]),
            .p_i(sync2_q[2*g]),
            .n_i(sync2_q[2*g+1]),
            .fault_o(mon_flag[g])
        );
    end

    // ==========================================================
    // Level selection
    wire logic a_lvl = src24 ? f24[0] : (sync2_q[0] & ~sync2_q[1]);
    wire logic b_raw = src24 ? f24[1] : (sync2_q[2] & ~sync2_q[3]);
    wire logic z_lvl = src24 ? f24[2] : (sync2_q[4] & ~sync2_q[5]);
    wire logic b_inc = b_raw ^ inv;
    // Direction level ignores inversion in both pulse modes
    wire logic dir_fwd = src24 ? ~f24[1] : (~sync2_q[2] & sync2_q[3]);

    logic a_q;
    logic b_q;
    logic z_q;

    wire logic a_edge = a_lvl ^ a_q;
    wire logic b_edge = b_inc ^ b_q;
    wire logic a_rise = a_lvl & ~a_q;
    wire logic z_rise = z_lvl & ~z_q;

    // ==========================================================
    // Incremental decode
    wire logic a_fwd = a_lvl ^ b_inc;
    wire logic b_fwd = ~(b_inc ^ a_lvl);
    wire logic inc_fwd = (eval == EIF_EV_SINGLE) ? (a_edge & ~b_inc & a_lvl) :
                         (a_edge ? a_fwd : ((eval == EIF_EV_FOUR) & b_edge & b_fwd));
    wire logic inc_bwd = (eval == EIF_EV_SINGLE) ? (a_edge & ~b_inc & ~a_lvl) :
                         (a_edge ? ~a_fwd : ((eval == EIF_EV_FOUR) & b_edge & ~b_fwd));

    // ==========================================================
    // Pulse decode, every rising A edge counts
    wire logic pls_fwd = a_rise & dir_fwd;
    wire logic pls_bwd = a_rise & ~dir_fwd;

    wire logic fwd_d = pulse_mode ? pls_fwd : inc_fwd;
    wire logic bwd_d = pulse_mode ? pls_bwd : inc_bwd;
    wire logic load_d = zero_en & z_rise;
    wire logic [2:0] fault_d = mon_flag & mon_eff;

    logic fwd_q;
    logic bwd_q;
    logic load_q;
    logic [2:0] fault_q;
    logic [EIF_DW-1:0] rdata_q;

    wire logic [EIF_DW-1:0] stat_word = {{(EIF_DW-7){1'b0}}, dir_fwd, z_lvl, b_inc, a_lvl, fault_q};
    wire logic [EIF_DW-1:0] rd_d = !rd_i ? '0 :
                                   sel_ctrl ? {{(EIF_DW-EIF_CTRL_W){1'b0}}, ctrl_q} :
                                   sel_stat ? stat_word : '0;

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            a_q <= 1'b0;
            b_q <= 1'b0;
            z_q <= 1'b0;
            fwd_q <= 1'b0;
            bwd_q <= 1'b0;
            load_q <= 1'b0;
            fault_q <= '0;
            rdata_q <= '0;
        end else if (ce_i) begin
            a_q <= a_lvl;
            b_q <= b_inc;
            z_q <= z_lvl;
            fwd_q <= fwd_d;
            bwd_q <= bwd_d;
            load_q <= load_d;
            fault_q <= fault_d;
            rdata_q <= rd_d;
        end
    end

    assign fwd_pulse_o = fwd_q;
    assign bwd_pulse_o = bwd_q;
    assign load_req_o = load_q;
    assign fault_o = fault_q;
    assign rdata_o = rdata_q;

    // ==========================================================
    // Checks
    property p_sync_chain;
        @(posedge core_clk_i) disable iff (!rstn_i)
        rstn_i && ce_i ##1 ce_i |=> sync2_q == $past(raw, 2);
    endproperty
    a_sync_chain: assert property (p_sync_chain) else $error("synchroniser latency wrong");

    property p_reset_ctrl;
        @(posedge core_clk_i) disable iff (!rstn_i)
        $rose(rstn_i) |-> ctrl_q == EIF_CTRL_RST;
    endproperty
    a_reset_ctrl: assert property (p_reset_ctrl) else $error("control not at reset value");

    property p_single_eval;
        @(posedge core_clk_i) disable iff (!rstn_i)
        ce_i && !pulse_mode && (eval == EIF_EV_SINGLE) && a_edge && !b_inc
        |=> (fwd_pulse_o == $past(a_lvl)) && (bwd_pulse_o == !$past(a_lvl));
    endproperty
    a_single_eval: assert property (p_single_eval) else $error("single evaluation pulse wrong");

    property p_diff_pulse_dir;
        @(posedge core_clk_i) disable iff (!rstn_i)
        ce_i && pulse_mode && !src24 && a_rise
        |=> fwd_pulse_o == ($past(!sync2_q[2]) && $past(sync2_q[3])) && (bwd_pulse_o != fwd_pulse_o);
    endproperty
    a_diff_pulse_dir: assert property (p_diff_pulse_dir) else $error("pulse direction wrong");

    property p_pulse_no_fall;
        @(posedge core_clk_i) disable iff (!rstn_i)
        ce_i && pulse_mode && !a_rise |=> !fwd_pulse_o && !bwd_pulse_o;
    endproperty
    a_pulse_no_fall: assert property (p_pulse_no_fall) else $error("pulse mode counted non-rising edge");

    property p_pulse24_dir;
        @(posedge core_clk_i) disable iff (!rstn_i)
        ce_i && pulse_mode && src24 && a_rise && f24[1] |=> bwd_pulse_o && !fwd_pulse_o;
    endproperty
    a_pulse24_dir: assert property (p_pulse24_dir) else $error("24 V direction input ignored");

    property p_mon_forced_off;
        @(posedge core_clk_i) disable iff (!rstn_i)
        ce_i && src24 |=> fault_o == 3'h0;
    endproperty
    a_mon_forced_off: assert property (p_mon_forced_off) else $error("fault shown with 24 V source");

    property p_zero_load;
        @(posedge core_clk_i) disable iff (!rstn_i)
        ce_i && z_rise |=> load_req_o == $past(zero_en);
    endproperty
    a_zero_load: assert property (p_zero_load) else $error("zero mark load request wrong");

    property p_excl;
        @(posedge core_clk_i) disable iff (!rstn_i)
        !(fwd_pulse_o && bwd_pulse_o);
    endproperty
    a_excl: assert property (p_excl) else $error("forward and backward at once");

    property p_ce_freeze;
        @(posedge core_clk_i) disable iff (!rstn_i)
        !ce_i |=> $stable(fwd_pulse_o) && $stable(bwd_pulse_o) && $stable(load_req_o) && $stable(fault_o)
                  && $stable(rdata_o) && $stable(ctrl_q) && $stable(sync2_q);
    endproperty
    a_ce_freeze: assert property (p_ce_freeze) else $error("state moved with clock enable low");

    property p_double_eval;
        @(posedge core_clk_i) disable iff (!rstn_i)
        ce_i && !pulse_mode && (eval == EIF_EV_DOUBLE) && a_edge
        |=> (fwd_pulse_o == ($past(a_lvl) != $past(b_inc))) && (bwd_pulse_o == ($past(a_lvl) == $past(b_inc)));
    endproperty
    a_double_eval: assert property (p_double_eval) else $error("double evaluation pulse wrong");

    property p_four_b_edge;
        @(posedge core_clk_i) disable iff (!rstn_i)
        ce_i && !pulse_mode && (eval == EIF_EV_FOUR) && b_edge && !a_edge
        |=> (fwd_pulse_o == ($past(a_lvl) == $past(b_inc))) && (bwd_pulse_o == ($past(a_lvl) != $past(b_inc)));
    endproperty
    a_four_b_edge: assert property (p_four_b_edge) else $error("fourfold lagging edge pulse wrong");

    property p_inc24_inv;
        @(posedge core_clk_i) disable iff (!rstn_i)
        ce_i && !pulse_mode && src24 && (eval == EIF_EV_SINGLE) && a_rise && (f24[1] == inv)
        |=> fwd_pulse_o && !bwd_pulse_o;
    endproperty
    a_inc24_inv: assert property (p_inc24_inv) else $error("24 V incremental inversion wrong");

    property p_fault_en;
        @(posedge core_clk_i) disable iff (!rstn_i)
        ce_i |=> (fault_o & ~$past(mon_en)) == 3'h0;
    endproperty
    a_fault_en: assert property (p_fault_en) else $error("fault on unmonitored pair");

    property p_stat_fault;
        @(posedge core_clk_i) disable iff (!rstn_i)
        ce_i && rd_i && sel_stat |=> rdata_o[2:0] == $past(fault_o);
    endproperty
    a_stat_fault: assert property (p_stat_fault) else $error("status fault bits wrong");

    property p_rd_idle;
        @(posedge core_clk_i) disable iff (!rstn_i)
        ce_i && !rd_i |=> rdata_o == '0;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read cycle");

    property p_pulse_count;
        @(posedge core_clk_i) disable iff (!rstn_i)
        ce_i && pulse_mode && a_rise |=> fwd_pulse_o != bwd_pulse_o;
    endproperty
    a_pulse_count: assert property (p_pulse_count) else $error("pulse mode dropped a count");

    property p_load_rise;
        @(posedge core_clk_i) disable iff (!rstn_i)
        ce_i && !z_rise |=> !load_req_o;
    endproperty
    a_load_rise: assert property (p_load_rise) else $error("load request without zero mark edge");

endmodule

// ===== verification/eif_enc_model.sv
// Behavioural encoder model driving the differential and 24 V inputs
`timescale 1ns/1ns
module eif_enc_model (
    input wire logic a_i,
    input wire logic b_i,
    input wire logic z_i,
    input wire logic sel24_i,
    input wire logic [2:0] conn_i,
    output logic a_p_o,
    output logic a_n_o,
    output logic b_p_o,
    output logic b_n_o,
    output logic z_p_o,
    output logic z_n_o,
    output logic a24_o,
    output logic b24_o,
    output logic z24_o
);
    // ==========================================================
    // Differential pairs, an unplugged pair rests with both lines low
    wire logic [2:0] on = conn_i & {3{~sel24_i}};
    assign a_p_o = on[0] & a_i;
    assign a_n_o = on[0] & ~a_i;
    assign b_p_o = on[1] & b_i;
    assign b_n_o = on[1] & ~b_i;
    assign z_p_o = on[2] & z_i;
    assign z_n_o = on[2] & ~z_i;
    // ==========================================================
    // Single-ended lines, an open terminal reads low
    assign a24_o = sel24_i & a_i;
    assign b24_o = sel24_i & b_i;
    assign z24_o = sel24_i & z_i;
endmodule

// ===== verification/testbench.sv
// Self-checking testbench for the encoder input front end
`timescale 1ns/1ns
module testbench;
    import eif_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic ce = 1'b1;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic a = 1'b0;
    logic b = 1'b0;
    logic z = 1'b0;
    logic sel24 = 1'b0;
    logic [2:0] conn = 3'h7;
    wire logic ap, an, bp, bn, zp, zn, a24, b24, z24;
    logic fwd, bwd, ld;
    logic [2:0] flt;
    int failures = 0;
    int checks = 0;
    int nf = 0;
    int nb = 0;
    int nl = 0;

    // ==========================================================
    // Clock, reset and pulse counters
    always #5 clk = ~clk;
    initial begin
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
    end
    always @(posedge clk) begin
        if (fwd === 1'b1) nf <= nf + 1;
        if (bwd === 1'b1) nb <= nb + 1;
        if (ld === 1'b1) nl <= nl + 1;
    end

    eif_enc_model eif_enc_model_i (.a_i(a), .b_i(b), .z_i(z), .sel24_i(sel24), .conn_i(conn),
        .a_p_o(ap), .a_n_o(an), .b_p_o(bp), .b_n_o(bn), .z_p_o(zp), .z_n_o(zn),
        .a24_o(a24), .b24_o(b24), .z24_o(z24));
    eif_front_end eif_front_end_i (.core_clk_i(clk), .rstn_i(rstn), .ce_i(ce), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .a_p_i(ap), .a_n_i(an),
        .b_p_i(bp), .b_n_i(bn), .z_p_i(zp), .z_n_i(zn), .a24_i(a24), .b24_i(b24), .z24_i(z24),
        .fwd_pulse_o(fwd), .bwd_pulse_o(bwd), .load_req_o(ld), .fault_o(flt));

    // ==========================================================
    // Shared tasks
    task automatic finish_test;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic clr;
        @(negedge clk);
        nf = 0;
        nb = 0;
        nl = 0;
    endtask
    task automatic wr_reg(input logic [7:0] ad, input logic [31:0] d);
        @(posedge clk);
        addr <= ad;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] ad, input logic [31:0] exp, input string nm);
        @(posedge clk);
        addr <= ad;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk(nm, rdata, exp);
        @(negedge clk);
        chk({nm, " gone"}, rdata, 32'h0);
    endtask
    task automatic cfg(input logic [31:0] d, input int w);
        wr_reg(EIF_CTRL_OFS, d);
        cyc(w);
        clr;
    endtask
    task automatic cnt(input string nm, input int ef, input int eb);
        chk({nm, " fwd"}, 32'(nf), 32'(ef));
        chk({nm, " bwd"}, 32'(nb), 32'(eb));
        clr;
    endtask
    task automatic quad(input bit fw, input int w);
        logic [1:0] f [4];
        f = '{2'b10, 2'b11, 2'b01, 2'b00};
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            {a, b} <= fw ? f[i] : f[(i == 3) ? 3 : 2 - i];
            cyc(w);
        end
    endtask
    task automatic puls(input int n, input int w);
        repeat (n) begin
            @(posedge clk);
            a <= 1'b1;
            cyc(w);
            @(posedge clk);
            a <= 1'b0;
            cyc(w);
        end
    endtask

    // ==========================================================
    // Scenarios
    task automatic s_bus;
        wr_reg(8'h08, 32'h0000ffff);
        rd_reg(EIF_CTRL_OFS, 32'h000001c0, "ctrl reset");
        rd_reg(8'h08, 32'h0, "unmapped");
        @(posedge clk);
        a <= 1'b1;
        repeat (2) @(posedge clk);
        #1 chk("fwd early", 32'(fwd), 32'h0);
        @(posedge clk);
        #1 chk("fwd sync", 32'(fwd), 32'h1);
        @(posedge clk);
        a <= 1'b0;
        cyc(8);
        cnt("single", 1, 1);
    endtask
    task automatic s_ce;
        @(posedge clk);
        ce <= 1'b0;
        a <= 1'b1;
        wr_reg(EIF_CTRL_OFS, 32'h000001c4);
        cyc(8);
        cnt("frozen", 0, 0);
        @(posedge clk);
        ce <= 1'b1;
        cyc(8);
        cnt("thawed", 1, 0);
        rd_reg(EIF_CTRL_OFS, 32'h000001c0, "ctrl kept");
        @(posedge clk);
        a <= 1'b0;
        cyc(8);
        clr;
        wr_reg(EIF_CTRL_OFS, 32'h000003c5);
        @(posedge clk);
        rstn <= 1'b0;
        cyc(3);
        rstn <= 1'b1;
        cyc(2);
        rd_reg(EIF_CTRL_OFS, 32'h000001c0, "ctrl reset again");
        cyc(8);
        cnt("after reset", 0, 0);
    endtask
    task automatic s_quad;
        quad(1, 8);
        cnt("quad fw", 1, 0);
        quad(0, 8);
        cnt("quad bw", 0, 1);
        cfg(32'h000001c8, 8);
        quad(1, 8);
        cnt("dbl fw", 2, 0);
        quad(0, 8);
        cnt("dbl bw", 0, 2);
        cfg(32'h000001d0, 8);
        quad(1, 8);
        cnt("four fw", 4, 0);
        quad(0, 8);
        cnt("four bw", 0, 4);
        cfg(32'h000001c4, 8);
        quad(1, 8);
        cnt("inv fw", 0, 1);
        quad(0, 8);
        cnt("inv bw", 1, 0);
        @(posedge clk);
        sel24 <= 1'b1;
        cfg(32'h000003c5, 300);
        quad(1, 300);
        cnt("24 inv", 0, 1);
        quad(0, 300);
        cnt("24 inv bw", 1, 0);
        chk("24 fault", 32'(flt), 32'h0);
    endtask
    task automatic s_pulse;
        @(posedge clk);
        sel24 <= 1'b0;
        cfg(32'h000001de, 8);
        puls(3, 8);
        cnt("dp fw", 3, 0);
        @(posedge clk);
        b <= 1'b1;
        cyc(8);
        puls(2, 8);
        cnt("dp bw", 0, 2);
        @(posedge clk);
        conn <= 3'b101;
        cfg(32'h0000015e, 8);
        puls(2, 8);
        cnt("dp open", 0, 2);
        chk("dp unmon", 32'(flt), 32'h0);
        @(posedge clk);
        conn <= 3'h7;
        sel24 <= 1'b1;
        cfg(32'h000003c7, 300);
        puls(2, 300);
        cnt("p24 bw", 0, 2);
        @(posedge clk);
        b <= 1'b0;
        cyc(300);
        puls(2, 300);
        cnt("p24 fw", 2, 0);
    endtask
    task automatic s_filter;
        puls(1, 100);
        cnt("short rej", 0, 0);
        puls(1, 250);
        cnt("short ok", 1, 0);
        cfg(32'h000001c7, 2000);
        puls(1, 1000);
        cnt("long rej", 0, 0);
        puls(1, 2500);
        cnt("long ok", 1, 0);
    endtask
    task automatic s_zero;
        for (int e = 1; e >= 0; e--) begin
            @(posedge clk);
            sel24 <= 1'b0;
            cfg(e ? 32'h000001e0 : 32'h000001c0, 8);
            @(posedge clk);
            z <= 1'b1;
            cyc(8);
            @(posedge clk);
            z <= 1'b0;
            cyc(8);
            chk("zero load", 32'(nl), 32'(e));
        end
    endtask
    task automatic s_fault;
        @(posedge clk);
        conn <= 3'b110;
        cyc(150);
        chk("fault a", 32'(flt), 32'h1);
        rd_reg(EIF_STAT_OFS, 32'h00000041, "status");
        cfg(32'h00000180, 4);
        chk("fault off", 32'(flt), 32'h0);
        cfg(32'h000001c0, 0);
        @(posedge clk);
        conn <= 3'h0;
        cyc(150);
        chk("fault all", 32'(flt), 32'h7);
        @(posedge clk);
        conn <= 3'h7;
        cyc(8);
        chk("fault gone", 32'(flt), 32'h0);
    endtask

    // ==========================================================
    // Main sequence and watchdog
    initial begin
        repeat (14) @(posedge clk);
        clr;
        s_bus;
        s_ce;
        s_quad;
        s_pulse;
        s_filter;
        s_zero;
        s_fault;
        finish_test;
    end
    initial begin
        #1000000;
        failures++;
        finish_test;
    end
endmodule
